/* design/conv_sequencer.sv */
// conv_sequencer: convert, sleep and data output sequencing of a delta-sigma converter
// What this block does
// - internal 60 Hz: 133 ms or 67 ms
// - internal 50 Hz: 160 ms or 80 ms
// - internal 50/60 Hz: 147 ms or 73.6 ms
// - external clock: 41036 or 20556 periods
// - sleep while chip select stays high
// - internal clock, internal oscillator: 24 cycles max
// - internal clock, external oscillator: 192 periods max
// - external serial clock: at most 24 cycles
// - source switch spoils only current conversion
// - source switch in output keeps data valid
// - exactly one output word per conversion
// - calibration inside conversion, timing unchanged
// - low supply holds the device in reset
// - supply good starts 4 ms power-on reset
// - reset clears all, then converts and cycles
// - temperature sensor forces gain of one
// - temperature sensor forces normal speed, offset calibration
// - distinct codes above and below full scale
// - internal/external clock, 3/4 wire, single/continuous
// - static pin level internal, toggling pin external
// - detect at 10 kHz, gate internal oscillator
// - rejection defaults to simultaneous 50/60 Hz
// - 24th falling serial edge starts conversion
// - chip select rise aborts, partial config dropped
module conv_sequencer #(
	parameter seq_pkg::cnt_t POR_CYC          = seq_pkg::cnt_t'(seq_pkg::POR_CYC),
	parameter seq_pkg::cnt_t CONV_60_1X_CYC   = seq_pkg::cnt_t'(seq_pkg::CONV_60_1X_CYC),
	parameter seq_pkg::cnt_t CONV_60_2X_CYC   = seq_pkg::cnt_t'(seq_pkg::CONV_60_2X_CYC),
	parameter seq_pkg::cnt_t CONV_50_1X_CYC   = seq_pkg::cnt_t'(seq_pkg::CONV_50_1X_CYC),
	parameter seq_pkg::cnt_t CONV_50_2X_CYC   = seq_pkg::cnt_t'(seq_pkg::CONV_50_2X_CYC),
	parameter seq_pkg::cnt_t CONV_BOTH_1X_CYC = seq_pkg::cnt_t'(seq_pkg::CONV_BOTH_1X_CYC),
	parameter seq_pkg::cnt_t CONV_BOTH_2X_CYC = seq_pkg::cnt_t'(seq_pkg::CONV_BOTH_2X_CYC),
	parameter seq_pkg::cnt_t EXT_1X_PER       = seq_pkg::cnt_t'(seq_pkg::EXT_1X_PER),
	parameter seq_pkg::cnt_t EXT_2X_PER       = seq_pkg::cnt_t'(seq_pkg::EXT_2X_PER)
) (
	input  wire logic        CLOCK,
	input  wire logic        RESETN,
	input  wire logic        CS_N,
	input  wire logic        SCK_IN,
	output logic             SCK_O,
	output logic             SCK_OE,
	input  wire logic        SDI,
	output logic             SDO_O,
	output logic             SDO_OE,
	input  wire logic        REJECTION_CLOCK_PIN,
	input  wire logic        RESULT_SIGN,
	input  wire logic [16:0] RESULT_DATA,
	input  wire logic        RESULT_OVER,
	input  wire logic        RESULT_UNDER,
	output logic             CONV_START,
	output logic             CONV_END,
	output logic             CONVERTING,
	output logic             CAL_ACTIVE,
	output logic             OFFSET_CAL_AUTO,
	output logic             INT_OSC_EN,
	output logic             EXT_CLOCK_PRESENT,
	output logic [2:0]       GAIN_EFF,
	output logic             TEMP_SELECT,
	output logic             SPEED_2X_EFF,
	output logic [1:0]       REJ_MODE,
	output logic             EXT_SCK_MODE,
	output logic             POR_ACTIVE,
	output logic [1:0]       SEQ_STATE
);
	localparam int CW = seq_pkg::CFG_W;
	localparam logic [4:0] LAST_BIT  = 5'(seq_pkg::DOUT_BITS - 1);
	localparam logic [4:0] CFG_LAST  = 5'(CW - 1);
	localparam logic [5:0] EDGES_MAX = 6'(2 * seq_pkg::DOUT_BITS);
	localparam logic [8:0] HALF_INT  = 9'(seq_pkg::SCK_HALF_CYC - 1);
	localparam logic [8:0] HALF_EXT  = 9'(seq_pkg::SCK_HALF_EXT - 1);

	// main clock domain state
	typedef struct packed {
		seq_pkg::seq_state_t state;    // sequencer state
		logic                por_done; // power-on reset interval over
		seq_pkg::cnt_t       cnt;      // power-on and conversion counter
		logic [CW-1:0]       cfg;      // configuration of the running conversion
		logic [23:0]         word;     // held result word
		logic                ext_sck;  // serial clock comes from the host
		logic                cs_prev;  // chip select one cycle ago
		logic                arm;      // link logic released from reset
		logic                eoc_n;    // end-of-conversion level, high while converting
		logic                cal;      // calibration phase flag
		logic                sck_o;    // generated serial clock
		logic [8:0]          div;      // half period divider
		logic [5:0]          edges;    // generated serial clock edges
		logic                start;    // conversion start pulse
		logic                done;     // conversion end pulse
	} main_t;
	// link domain, rising serial edge: input side
	typedef struct packed {
		logic [4:0]    cnt;     // rising edges seen, saturates
		logic [CW-1:0] sr;      // configuration shift register
		logic          full;    // whole configuration word loaded
		logic          started; // host began reading
	} rx_t;
	// link domain, falling serial edge: output side
	typedef struct packed {
		logic [4:0] cnt;  // falling edges seen, saturates
		logic       sdo;  // serial output bit
		logic       done; // 24th falling edge reached
	} tx_t;

	main_t m_q;
	main_t m_d;
	rx_t   rx_q;
	rx_t   rx_d;
	tx_t   tx_q;
	tx_t   tx_d;

	logic          cs_s;        // synchronised chip select, high = idle
	logic          sck_s;       // synchronised serial clock pin level
	logic          rej_s;       // synchronised rejection clock pin
	logic          full_s;      // link flags seen in the main domain
	logic          done_s;
	logic          started_s;
	logic          ext_present; // external conversion clock detected
	logic          ext_tick;    // one rising edge of it
	logic          link_rst_n;  // link logic held in reset unless armed
	logic          temp_sel;    // temperature sensor selected
	logic          spd2x;       // effective double speed
	logic [1:0]    rej;         // rejection mode field
	logic [2:0]    gain;        // effective gain code
	seq_pkg::cnt_t target;      // length of the present conversion
	logic          conv_tick;   // conversion time base advances
	logic          half_tick;   // serial clock divider advances
	logic [8:0]    half_max;    // divider terminal count
	logic [16:0]   code;        // clamped result field
	logic          code_sign;   // clamped sign bit
	logic [4:0]    bit_idx;     // word bit sent on the next falling edge

	// pins from outside cross through two flip-flops first
	sync2 #(.W(3), .INIT(3'h4)) u_pin_sync (
		.clk  (CLOCK),
		.rst_n(RESETN),
		.d    ({CS_N, SCK_IN, REJECTION_CLOCK_PIN}),
		.q    ({cs_s, sck_s, rej_s})
	);

	// link flags are levels that only clear with the link reset
	sync2 #(.W(3), .INIT(3'h0)) u_link_sync (
		.clk  (CLOCK),
		.rst_n(RESETN),
		.d    ({rx_q.full, tx_q.done, rx_q.started}),
		.q    ({full_s, done_s, started_s})
	);

	// a static pin level keeps the internal oscillator, a toggling one replaces it
	ext_clock_detect u_det (
		.clk    (CLOCK),
		.rst_n  (RESETN),
		.level  (rej_s),
		.present(ext_present),
		.tick   (ext_tick)
	);

	// forced settings while the temperature sensor is measured
	always_comb begin
		temp_sel = m_q.cfg[seq_pkg::CFG_TEMP_BIT];
		rej      = m_q.cfg[seq_pkg::CFG_REJ_LSB +: 2];
		spd2x    = m_q.cfg[seq_pkg::CFG_SPEED_BIT] & ~temp_sel;
		gain     = temp_sel ? seq_pkg::GAIN_1X : m_q.cfg[seq_pkg::CFG_GAIN_LSB +: 3];
	end

	// conversion length from the source running right now; a switch mid-way only
	// bends the conversion in flight, the next one starts clean
	always_comb begin
		if (ext_present) begin
			target = spd2x ? EXT_2X_PER : EXT_1X_PER;
		end else begin
			unique case (rej)
				seq_pkg::REJ_60: target = spd2x ? CONV_60_2X_CYC : CONV_60_1X_CYC;
				seq_pkg::REJ_50: target = spd2x ? CONV_50_2X_CYC : CONV_50_1X_CYC;
				default:         target = spd2x ? CONV_BOTH_2X_CYC : CONV_BOTH_1X_CYC;
			endcase
		end
		conv_tick = ext_present ? ext_tick : 1'b1;
		half_tick = ext_present ? ext_tick : 1'b1;
		half_max  = ext_present ? HALF_EXT : HALF_INT;
	end

	// out-of-range inputs get their own clamped codes
	always_comb begin
		if (RESULT_OVER) begin
			code_sign = 1'b1;
			code      = seq_pkg::CODE_OVER;
		end else if (RESULT_UNDER) begin
			code_sign = 1'b0;
			code      = seq_pkg::CODE_UNDER;
		end else begin
			code_sign = RESULT_SIGN;
			code      = RESULT_DATA;
		end
	end

	// main sequencer: power-on interval, then convert, sleep, data output
	always_comb begin
		m_d       = m_q;
		m_d.start = 1'b0;
		m_d.done  = 1'b0;
		m_d.cs_prev = cs_s;
		if (!m_q.por_done) begin
			// everything stays cleared until the interval runs out
			if (m_q.cnt == POR_CYC - 1'b1) begin
				m_d.por_done = 1'b1;
				m_d.cnt      = '0;
				m_d.state    = seq_pkg::S_CONVERT;
				m_d.start    = 1'b1;
				m_d.eoc_n    = 1'b1;
				m_d.ext_sck  = ~sck_s;
			end else begin
				m_d.cnt = m_q.cnt + 1'b1;
			end
		end else begin
			// serial clock source is picked again on every chip select fall
			if (m_q.cs_prev && !cs_s) begin
				m_d.ext_sck = ~sck_s;
			end
			unique case (m_q.state)
				seq_pkg::S_CONVERT: begin
					// calibration runs in the first eighth, inside the same length
					m_d.cal = m_q.cnt < (target >> 3);
					if (conv_tick) begin
						m_d.cnt = m_q.cnt + 1'b1;
					end
					if (conv_tick && (m_q.cnt >= target - 1'b1)) begin
						// one conversion, one word, captured once
						m_d.word  = {2'h0, code_sign, code, m_q.cfg[seq_pkg::CFG_GAIN_LSB +: 3], temp_sel};
						m_d.done  = 1'b1;
						m_d.cal   = 1'b0;
						m_d.cnt   = '0;
						m_d.eoc_n = 1'b0;
						m_d.state = seq_pkg::S_SLEEP;
					end
				end
				seq_pkg::S_SLEEP: begin
					// stays here while chip select is high; internal clock mode arms the link one
					// cycle after the pin is pulled low, so that drop is not taken as a serial edge
					m_d.arm = (~cs_s & m_d.ext_sck) | started_s;
					if (started_s) begin
						// host has clocked: go on even if chip select already rose, data output aborts
						m_d.state = seq_pkg::S_DATA;
					end else if (!cs_s && !m_q.ext_sck) begin
						// internal clock: output begins as soon as chip select is low
						m_d.state = seq_pkg::S_DATA;
						m_d.arm   = 1'b1;
						m_d.div   = '0;
						m_d.edges = '0;
						m_d.sck_o = 1'b0;
					end
				end
				seq_pkg::S_DATA: begin
					if (cs_s || done_s) begin
						// abort or 24th falling edge: start over right away; a partial
						// configuration word is dropped and the old one kept
						if (full_s) begin
							m_d.cfg = rx_q.sr;
						end
						m_d.state = seq_pkg::S_CONVERT;
						m_d.arm   = 1'b0;
						m_d.start = 1'b1;
						m_d.eoc_n = 1'b1;
						m_d.cnt   = '0;
						m_d.sck_o = 1'b0;
					end else if (!m_q.ext_sck && half_tick && (m_q.edges != EDGES_MAX)) begin
						// generated clock stops after 24 cycles
						if (m_q.div == half_max) begin
							m_d.div   = '0;
							m_d.sck_o = ~m_q.sck_o;
							m_d.edges = m_q.edges + 1'b1;
						end else begin
							m_d.div = m_q.div + 1'b1;
						end
					end
				end
			endcase
		end
	end

	// main registers; a low supply holds all of them cleared
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			m_q       <= '0;
			m_q.cfg   <= seq_pkg::CFG_RESET;
			m_q.state <= seq_pkg::S_CONVERT;
		end else begin
			m_q <= m_d;
		end
	end

	// the link logic only runs while the main side has armed it
	assign link_rst_n = m_q.arm;

	// rising serial edges shift the configuration in, first edge included
	always_comb begin
		rx_d         = rx_q;
		rx_d.started = 1'b1;
		if (rx_q.cnt != LAST_BIT + 1'b1) begin
			rx_d.cnt = rx_q.cnt + 1'b1;
		end
		if (rx_q.cnt < 5'(CW)) begin
			rx_d.sr = {rx_q.sr[CW-2:0], SDI};
			if (rx_q.cnt == CFG_LAST) begin
				rx_d.full = 1'b1;
			end
		end
	end

	always_ff @(posedge SCK_IN or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rx_q <= '0;
		end else begin
			rx_q <= rx_d;
		end
	end

	// falling serial edges move the next bit out; the word register stays still
	// while the link is armed, so it is read here without a crossing
	assign bit_idx = 5'(seq_pkg::DOUT_BITS - 2) - tx_q.cnt;

	always_comb begin
		tx_d = tx_q;
		if (tx_q.cnt < LAST_BIT) begin
			tx_d.cnt = tx_q.cnt + 1'b1;
			tx_d.sdo = m_q.word[bit_idx];
		end else begin
			// 24th edge and any extra ones: output held high
			tx_d.cnt  = LAST_BIT + 1'b1;
			tx_d.sdo  = 1'b1;
			tx_d.done = 1'b1;
		end
	end

	always_ff @(negedge SCK_IN or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_q <= '0;
		end else begin
			tx_q <= tx_d;
		end
	end

	// pins: data line shows the end-of-conversion level until the first falling serial edge; the
	// main state lags the link by a synchroniser and would hide the first bits of a fast frame
	assign SDO_O  = (tx_q.cnt != 5'h00) ? tx_q.sdo : m_q.eoc_n;
	assign SDO_OE = ~cs_s;
	assign SCK_O  = m_q.sck_o;
	assign SCK_OE = m_q.por_done & ~m_q.ext_sck & ~cs_s;

	// status and forced settings
	assign CONV_START        = m_q.start;
	assign CONV_END          = m_q.done;
	assign CONVERTING        = m_q.eoc_n;
	assign CAL_ACTIVE        = m_q.cal;
	assign OFFSET_CAL_AUTO   = temp_sel;
	assign INT_OSC_EN        = ~ext_present;
	assign EXT_CLOCK_PRESENT = ext_present;
	assign GAIN_EFF          = gain;
	assign TEMP_SELECT       = temp_sel;
	assign SPEED_2X_EFF      = spd2x;
	assign REJ_MODE          = rej;
	assign EXT_SCK_MODE      = m_q.ext_sck;
	assign POR_ACTIVE        = ~m_q.por_done;
	assign SEQ_STATE         = m_q.state;
endmodule

/* design/ext_clock_detect.sv */
// ext_clock_detect: tells a toggling conversion clock from a static level
module ext_clock_detect (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic level,    // synchronised pin level
	output logic      present,  // toggling fast enough to be a clock
	output logic      tick      // one-cycle pulse per rising edge while present
);
	localparam int GAP_W = $clog2(seq_pkg::DET_GAP_CYC + 1);
	localparam logic [GAP_W-1:0] GAP_MAX = GAP_W'(seq_pkg::DET_GAP_CYC);
	typedef struct packed {
		logic             prev;    // level one cycle ago
		logic [GAP_W-1:0] gap;     // cycles since the last rising edge
		logic             seen;    // one rising edge seen inside the window
		logic             present; // clock declared present
	} det_t;
	det_t r_q;
	det_t r_d;
	logic rise;

	assign rise = level & ~r_q.prev;

	// two close rising edges declare a clock; a long gap withdraws it
	always_comb begin
		r_d      = r_q;
		r_d.prev = level;
		if (rise) begin
			r_d.gap     = '0;
			r_d.seen    = 1'b1;
			r_d.present = r_q.seen;
		end else if (r_q.gap == GAP_MAX) begin
			r_d.seen    = 1'b0;
			r_d.present = 1'b0;
		end else begin
			r_d.gap = r_q.gap + 1'b1;
		end
	end

	// registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign present = r_q.present;
	assign tick    = rise & r_q.present;
endmodule

/* design/seq_pkg.sv */
// package: timing, configuration layout and state codes of the converter sequencer
package seq_pkg;
	localparam int CLK_MHZ         = 20;                          // main clock rate in MHz
	localparam int CNT_W           = 23;                          // width of the long cycle counters
	typedef logic [CNT_W-1:0] cnt_t;                              // long counter type
	// convert state length, internal oscillator, in microseconds
	localparam int CONV_60_1X_US   = 133000;
	localparam int CONV_60_2X_US   = 67000;
	localparam int CONV_50_1X_US   = 160000;
	localparam int CONV_50_2X_US   = 80000;
	localparam int CONV_BOTH_1X_US = 147000;
	localparam int CONV_BOTH_2X_US = 73600;
	localparam int CONV_60_1X_CYC   = CONV_60_1X_US * CLK_MHZ;
	localparam int CONV_60_2X_CYC   = CONV_60_2X_US * CLK_MHZ;
	localparam int CONV_50_1X_CYC   = CONV_50_1X_US * CLK_MHZ;
	localparam int CONV_50_2X_CYC   = CONV_50_2X_US * CLK_MHZ;
	localparam int CONV_BOTH_1X_CYC = CONV_BOTH_1X_US * CLK_MHZ;
	localparam int CONV_BOTH_2X_CYC = CONV_BOTH_2X_US * CLK_MHZ;
	// convert state length, external conversion clock, in its periods
	localparam int EXT_1X_PER      = 41036;
	localparam int EXT_2X_PER      = 20556;
	// power-on reset length
	localparam int POR_US          = 4000;
	localparam int POR_CYC         = POR_US * CLK_MHZ;
	// data output: word length and internal serial clock limits
	localparam int DOUT_BITS       = 24;
	localparam int DOUT_INT_US     = 620;
	localparam int SCK_HALF_CYC    = DOUT_INT_US * CLK_MHZ / (2 * DOUT_BITS);
	localparam int EXT_DOUT_PER    = 192;
	localparam int SCK_HALF_EXT    = EXT_DOUT_PER / (2 * DOUT_BITS);
	// external conversion clock detection floor
	localparam int DET_MIN_HZ      = 10000;
	localparam int DET_GAP_CYC     = CLK_MHZ * 1000000 / DET_MIN_HZ;
	// configuration word shifted in on the data input, first bit is the top bit
	localparam int CFG_W           = 7;
	localparam int CFG_GAIN_LSB    = 4;
	localparam int CFG_TEMP_BIT    = 3;
	localparam int CFG_REJ_LSB     = 1;
	localparam int CFG_SPEED_BIT   = 0;
	localparam logic [1:0] REJ_BOTH = 2'h0;                       // simultaneous 50/60 Hz
	localparam logic [1:0] REJ_50   = 2'h1;
	localparam logic [1:0] REJ_60   = 2'h2;
	localparam logic [2:0] GAIN_1X  = 3'h0;
	localparam logic [CFG_W-1:0] CFG_RESET = {GAIN_1X, 1'h0, REJ_BOTH, 1'h0};
	// clamped result codes beyond full scale
	localparam logic [16:0] CODE_OVER  = 17'h10000;
	localparam logic [16:0] CODE_UNDER = 17'h0FFFF;
	typedef enum logic [1:0] {S_CONVERT, S_SLEEP, S_DATA} seq_state_t;
endpackage

/* design/sync2.sv */
// sync2: two flip-flop synchroniser for a group of level signals
module sync2 #(
	parameter int             W    = 1,
	parameter logic [W-1:0]   INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;   // first stage, read only by s2
		logic [W-1:0] s2;   // settled copy
	} sync_t;
	sync_t r_q;
	sync_t r_d;

	// next state: plain shift
	always_comb begin
		r_d    = r_q;
		r_d.s1 = d;
		r_d.s2 = r_q.s1;
	end

	// registers, reset to the idle level of the pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q <= {INIT, INIT};
		end else begin
			r_q <= r_d;
		end
	end

	assign q = r_q.s2;
endmodule

/* tb/conv_sequencer_monitor.sv */
// checker: port-level timing and ordering checks of the converter sequencer
module conv_sequencer_monitor #(
	parameter seq_pkg::cnt_t CONV_60_1X_CYC   = 1,
	parameter seq_pkg::cnt_t CONV_50_1X_CYC   = 1,
	parameter seq_pkg::cnt_t CONV_BOTH_1X_CYC = 1
) (
	input wire logic       CLOCK,
	input wire logic       RESETN,
	input wire logic       CS_N,
	input wire logic       CONV_START,
	input wire logic       CONV_END,
	input wire logic       CONVERTING,
	input wire logic       POR_ACTIVE,
	input wire logic       INT_OSC_EN,
	input wire logic       EXT_CLOCK_PRESENT,
	input wire logic       TEMP_SELECT,
	input wire logic       SPEED_2X_EFF,
	input wire logic       OFFSET_CAL_AUTO,
	input wire logic [2:0] GAIN_EFF,
	input wire logic [1:0] REJ_MODE,
	input wire logic [1:0] SEQ_STATE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	seq_pkg::cnt_t len_q; // cycles since the last conversion start
	seq_pkg::cnt_t want;  // normal-speed length for the present rejection mode
	// count from the start pulse so the end pulse can be tied to it
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			len_q <= '0;
		end else begin
			len_q <= CONV_START ? seq_pkg::cnt_t'(1) : len_q + 1'b1;
		end
	end
	// expected length picked from the decoded rejection mode
	always_comb begin
		case (REJ_MODE)
			seq_pkg::REJ_60: want = CONV_60_1X_CYC;
			seq_pkg::REJ_50: want = CONV_50_1X_CYC;
			default:         want = CONV_BOTH_1X_CYC;
		endcase
	end
	sequence cs_idle;
		CS_N [*4];
	endsequence
	sequence abort_seq;
		SEQ_STATE == 2'h2 ##1 $rose(CS_N);
	endsequence
	chk_por_start: assert property ($fell(POR_ACTIVE) |-> CONV_START && SEQ_STATE == 2'h0) else $error("no start at reset end");
	chk_conv_len: assert property (CONV_END && INT_OSC_EN && !SPEED_2X_EFF |-> len_q == want) else $error("bad convert length");
	chk_end_sleep: assert property (CONV_END |-> SEQ_STATE == 2'h1 && !CONVERTING) else $error("end not into sleep");
	chk_start_conv: assert property (CONV_START |-> CONVERTING && SEQ_STATE == 2'h0) else $error("start not converting");
	chk_sleep_hold: assert property (cs_idle ##0 SEQ_STATE == 2'h1 |=> SEQ_STATE == 2'h1) else $error("left sleep");
	chk_abort_start: assert property (abort_seq |-> ##[1:4] CONV_START) else $error("abort without start");
	chk_temp_gain: assert property (TEMP_SELECT |-> GAIN_EFF == 3'h0) else $error("gain not one");
	chk_temp_speed: assert property (TEMP_SELECT |-> !SPEED_2X_EFF && OFFSET_CAL_AUTO) else $error("speed not forced");
	chk_osc_gate: assert property (INT_OSC_EN != EXT_CLOCK_PRESENT) else $error("oscillator gate wrong");
endmodule

bind conv_sequencer conv_sequencer_monitor #(.CONV_60_1X_CYC(CONV_60_1X_CYC), .CONV_50_1X_CYC(CONV_50_1X_CYC),
	.CONV_BOTH_1X_CYC(CONV_BOTH_1X_CYC)) mon (.CLOCK(CLOCK), .RESETN(RESETN), .CS_N(CS_N), .CONV_START(CONV_START),
	.CONV_END(CONV_END), .CONVERTING(CONVERTING), .POR_ACTIVE(POR_ACTIVE), .INT_OSC_EN(INT_OSC_EN),
	.EXT_CLOCK_PRESENT(EXT_CLOCK_PRESENT), .TEMP_SELECT(TEMP_SELECT), .SPEED_2X_EFF(SPEED_2X_EFF),
	.OFFSET_CAL_AUTO(OFFSET_CAL_AUTO), .GAIN_EFF(GAIN_EFF), .REJ_MODE(REJ_MODE), .SEQ_STATE(SEQ_STATE));

/* tb/host_model.sv */
// host model: microcontroller reading words over the external serial clock
module host_model (
	input  wire logic       clock,
	input  wire logic       sdo,
	output logic            cs_n,
	output logic            sck,
	output logic            sdi
);
	timeunit 1ns;
	timeprecision 1ps;
	// serial clock low at the chip-select fall selects the external mode
	initial begin
		cs_n = 1'h1;
		sck  = 1'h0;
		sdi  = 1'h0;
	end
	// one frame of n clocks, half period hp ns; config goes out top bit first
	task automatic frame(input logic [6:0] cfg, input int n, input int hp, output logic [23:0] w);
		int k;
		w = 24'h0;
		@(negedge clock);
		cs_n = 1'h0;
		repeat (5) @(negedge clock); // chip select must cross the synchroniser first
		for (k = 0; k < n; k++) begin
			sdi = (k < 7) ? cfg[6 - k] : 1'h0;
			#hp sck = 1'h1;
			w[23 - k] = sdo;
			#hp sck = 1'h0;
		end
		sdi = ~sdi; // a released line does not keep its last bit
		if (n == 24) begin
			repeat (8) @(negedge clock); // let the new conversion begin
		end
		cs_n = 1'h1;
	endtask
endmodule

/* tb/tb_conv_sequencer.sv */
// testbench: scenarios for the converter sequencer against a host model
module tb_conv_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int C60_1 = 64, C60_2 = 32, C50_1 = 80, C50_2 = 40, CB_1 = 72, CB_2 = 36;
	localparam int EXT_1 = 12, EXT_2 = 10, POR = 20;
	logic        clock, resetn, cs_n, sck_h, sck_o, sck_oe, sdi, sdo_o, r_sign, r_over, r_under;
	logic        conv_start, conv_end, converting, off_cal, int_osc, ext_pres, temp, speed_select_bit, por, ext_on;
	logic [16:0] r_data;
	logic [2:0]  gain;
	logic [1:0]  rej, state;
	logic [6:0]  cur = 7'h00;  // config of the conversion now running
	logic [3:0]  ph = 4'h0;    // phase of the external conversion clock
	logic        ext_pin = 1'b0;
	wire         sck_in = sck_oe ? sck_o : sck_h; // resolved serial clock pin
	int          n_fail = 0, checks_done = 0, len = 0, last_len = 0;
	conv_sequencer #(.POR_CYC(POR), .CONV_60_1X_CYC(C60_1), .CONV_60_2X_CYC(C60_2), .CONV_50_1X_CYC(C50_1),
		.CONV_50_2X_CYC(C50_2), .CONV_BOTH_1X_CYC(CB_1), .CONV_BOTH_2X_CYC(CB_2), .EXT_1X_PER(EXT_1),
		.EXT_2X_PER(EXT_2)) DUT (.CLOCK(clock), .RESETN(resetn), .CS_N(cs_n), .SCK_IN(sck_in), .SCK_O(sck_o),
		.SCK_OE(sck_oe), .SDI(sdi), .SDO_O(sdo_o), .SDO_OE(), .REJECTION_CLOCK_PIN(ext_pin), .RESULT_SIGN(r_sign),
		.RESULT_DATA(r_data), .RESULT_OVER(r_over), .RESULT_UNDER(r_under), .CONV_START(conv_start),
		.CONV_END(conv_end), .CONVERTING(converting), .CAL_ACTIVE(), .OFFSET_CAL_AUTO(off_cal), .INT_OSC_EN(int_osc),
		.EXT_CLOCK_PRESENT(ext_pres), .GAIN_EFF(gain), .TEMP_SELECT(temp), .SPEED_2X_EFF(speed_select_bit), .REJ_MODE(rej),
		.EXT_SCK_MODE(), .POR_ACTIVE(por), .SEQ_STATE(state));
	host_model host (.clock(clock), .sdo(sdo_o), .cs_n(cs_n), .sck(sck_h), .sdi(sdi));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// external conversion clock, ten main cycles a period, static low when off
	always @(negedge clock) begin
		ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
		ext_pin <= ext_on && ph < 4'h5;
	end
	// conversion length measured at settled outputs, start pulse counts as zero
	always @(negedge clock) begin
		len = conv_start ? 0 : len + 1;
		if (conv_end) last_len = len;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	function automatic int tgt(input logic [6:0] c);
		logic s;
		s = c[0] & ~c[3];
		case (c[2:1])
			seq_pkg::REJ_60: return s ? C60_2 : C60_1;
			seq_pkg::REJ_50: return s ? C50_2 : C50_1;
			default: return s ? CB_2 : CB_1;
		endcase
	endfunction
	function automatic logic [23:0] word(input logic [6:0] c);
		logic [17:0] v;
		v = r_over ? {1'b1, seq_pkg::CODE_OVER} : r_under ? {1'b0, seq_pkg::CODE_UNDER} : {r_sign, r_data};
		return {2'h0, v, c[6:4], c[3]};
	endfunction
	// bounded wait for the end of a conversion
	task automatic wait_end;
		int k;
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while (conv_end !== 1'b1 && k < 3000);
		#1; // let the length counter of this edge finish first
		chk(k < 3000, 1);
	endtask
	// read n bits of the held word while loading a config; a short frame aborts
	task automatic rd(input logic [6:0] c, input int n, input int hp);
		logic [23:0] w;
		host.frame(c, n, hp, w);
		chk(w >> (24 - n), word(cur) >> (24 - n));
		if (n == 24) cur = c;
	endtask
	task automatic t_por;
		int k;
		resetn = 1'b0;
		repeat (6) @(negedge clock);
		chk({por, rej, int_osc}, 4'h9);
		resetn = 1'b1;
		k = 0;
		while (por === 1'b1 && k < 100) begin
			@(negedge clock);
			k++;
		end
		chk(k, POR);
		chk({conv_start, state}, 3'h4);
		wait_end;
		chk(last_len, CB_1);
	endtask
	// every rejection and speed mode, gain and sensor select, range codes
	task automatic t_modes;
		logic [6:0] tab [6];
		int i;
		tab = '{7'h04, 7'h35, 7'h02, 7'h03, 7'h01, 7'h59};
		for (i = 0; i < 6; i++) begin
			rd(tab[i], 24, (i == 2) ? 30 : 3);
			r_over = (i == 1);
			r_under = (i == 2);
			r_sign = i[0];
			r_data = 17'(i * 32'h1111);
			wait_end;
			chk(last_len, tgt(tab[i]));
			if (tab[i][3]) chk({gain, speed_select_bit, off_cal}, 5'h01);
		end
	endtask
	// chip select rises after five clocks: old config kept, sleep held after
	task automatic t_abort;
		rd(7'h04, 5, 30);
		wait_end;
		chk({rej, 32'(last_len)}, {cur[2:1], 32'(tgt(cur))});
		repeat (40) @(negedge clock);
		chk(state, 2'h1);
	endtask
	task automatic t_ext;
		ext_on = 1'b1;
		repeat (40) @(negedge clock);
		chk({ext_pres, int_osc}, 2'h2);
		rd(7'h00, 24, 3);
		wait_end;
		chk(last_len >= 10 * EXT_1 - 12 && last_len <= 10 * EXT_1 + 12, 1);
		rd(7'h01, 24, 3);
		wait_end;
		chk(last_len >= 10 * EXT_2 - 12 && last_len <= 10 * EXT_2 + 12, 1);
		ext_on = 1'b0;
		repeat (2100) @(negedge clock);
		chk({ext_pres, int_osc}, 2'h1);
		rd(7'h02, 24, 3);
		wait_end;
		chk(last_len, C50_1);
	endtask
	// internal serial clock: pin left high at the chip-select fall, the device makes the 24 cycles
	task automatic t_int;
		logic [23:0] w;
		int k;
		@(negedge clock);
		host.sdi = 1'h0;
		host.sck = 1'h1;
		host.cs_n = 1'h0;
		repeat (4) @(negedge clock);
		for (k = 0; k < 24; k++) begin
			@(posedge sck_in);
			w[23 - k] = sdo_o;
		end
		chk(w, word(cur));
		cur = 7'h00;
		wait_end;
		chk({sck_in, 32'(last_len)}, {1'b0, 32'(tgt(cur))});
	endtask
	// hang guard, far beyond the span the scenarios need
	initial begin
		#2000000;
		n_fail++;
		stop_test;
	end
	initial begin
		resetn = 1'b0;
		ext_on = 1'b0;
		r_sign = 1'b1;
		r_data = 17'h0ABCD;
		r_over = 1'b0;
		r_under = 1'b0;
		t_por;
		t_modes;
		t_abort;
		t_ext;
		t_int;
		stop_test;
	end
endmodule
